// ===== rtl/fcl_pkg.sv
// Operation
// - Reset rising edge starts active flash load
// - Fabric held off until memory programmed
// - Modes active, passive, JTAG with widths
// - Active mode: own clock drives flash
// - Loader drives all flash instructions, addresses
// - First flash transaction is wake-up
// - Wait thirty microseconds after wake-up
// - Fast read from address zero sequentially
// - Third mode loads through JTAG port
package fcl_pkg;
   localparam int CLK_MHZ = 100;
   localparam int WAKE_WAIT_US = 30;
   localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CLK_MHZ;
   localparam logic [7:0] CMD_WAKE = 8'hAB;
   localparam logic [7:0] CMD_FAST_READ = 8'h0B;
   localparam logic [23:0] START_ADDR = 24'h00_0000;
   localparam int HDR_BITS = 40; // Command, address, dummy byte
   localparam int BITSTREAM_BYTES = 1024;
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_PASSIVE = 2'h1;
   localparam logic [1:0] MODE_JTAG = 2'h2;
   localparam logic [2:0] WID_X1 = 3'h0;
   localparam logic [2:0] WID_X2 = 3'h1;
   localparam logic [2:0] WID_X4 = 3'h2;
   localparam logic [2:0] WID_X8 = 3'h3;
   localparam logic [2:0] WID_X16 = 3'h4;
   localparam logic [2:0] WID_X32 = 3'h5;
   localparam logic [3:0] SCK_HALF = 4'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAKE = 3'b001,
      ST_WAIT = 3'b010,
      ST_HDR = 3'b011,
      ST_DATA = 3'b100,
      ST_PASV = 3'b101,
      ST_JTAG = 3'b110,
      ST_DONE = 3'b111
   } fcl_state_e;

   typedef struct packed {
      fcl_state_e st;
      logic [2:0] rst_sync;
      logic [2:0] pclk_sync;
      logic [2:0] tck_sync;
      logic [31:0] pdat_s1;
      logic [31:0] pdat_s2;
      logic [1:0] tdi_sync;
      logic [1:0] so_s1;
      logic [3:0] io_s1;
      logic [3:0] io_s2;
      logic so_s2;
      logic [3:0] div;
      logic [15:0] cnt;
      logic [39:0] shreg;
      logic [7:0] byte_acc;
      logic [5:0] bit_cnt;
      logic [31:0] bytes;
      logic sck;
      logic cs_low;
      logic mosi;
      logic [7:0] wr_data;
      logic wr_en;
      logic [31:0] wr_addr;
      logic done;
   } fcl_state_s;
endpackage

// ===== rtl/fcl_loader.sv
`timescale 1ns/1ns
`default_nettype none
module fcl_loader
   import fcl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic config_reset_low,
   input wire logic [1:0] mode_sel,
   input wire logic [2:0] width_sel,
   input wire logic flash_miso,
   input wire logic [3:0] flash_io_in,
   input wire logic pasv_clk,
   input wire logic [31:0] pasv_data,
   input wire logic tck,
   input wire logic tdi,
   output logic flash_sck,
   output logic flash_cs_b,
   output logic flash_mosi,
   output logic [7:0] cfg_wr_data,
   output logic cfg_wr_en,
   output logic [31:0] cfg_wr_addr,
   output logic config_done,
   output logic fabric_enable
);
   // Whole state in one packed struct
   fcl_state_s s_reg, s_next;
   logic [5:0] lanes;

   // Bits taken per link clock edge for the selected width
   always_comb begin
      case (width_sel)
         WID_X1: lanes = 6'h01;
         WID_X2: lanes = 6'h02;
         WID_X4: lanes = 6'h04;
         WID_X8: lanes = 6'h08;
         WID_X16: lanes = 6'h10;
         WID_X32: lanes = 6'h20;
         default: lanes = 6'h01;
      endcase
      // Width follows the live width pins, not latched at the start of the load
      if (s_reg.st == ST_DATA && width_sel > WID_X4) begin
         lanes = 6'h04; // Active mode tops out at four lanes
      end
      // Test access port carries one bit per clock
      if (s_reg.st == ST_JTAG) begin
         lanes = 6'h01;
      end
   end

   // Next-state logic
   always_comb begin
      logic sck_fall;
      logic p_rise;
      logic t_rise;
      logic [39:0] in_word;
      sck_fall = 1'b0;
      p_rise = 1'b0;
      t_rise = 1'b0;
      in_word = 40'h00_0000_0000;
      // Hold state; write strobe is a one-cycle pulse
      s_next = s_reg;
      s_next.wr_en = 1'b0;
      // Synchronisers; first stage read only by second
      s_next.rst_sync = {s_reg.rst_sync[1:0], config_reset_low};
      s_next.pclk_sync = {s_reg.pclk_sync[1:0], pasv_clk};
      s_next.tck_sync = {s_reg.tck_sync[1:0], tck};
      s_next.pdat_s1 = pasv_data;
      s_next.pdat_s2 = s_reg.pdat_s1;
      s_next.tdi_sync = {s_reg.tdi_sync[0], tdi};
      s_next.so_s1 = {s_reg.so_s1[0], flash_miso};
      s_next.so_s2 = s_reg.so_s1[1];
      s_next.io_s1 = flash_io_in;
      s_next.io_s2 = s_reg.io_s1;
      // Rising edges of the synced link clocks
      p_rise = s_reg.pclk_sync[1] & ~s_reg.pclk_sync[2];
      t_rise = s_reg.tck_sync[1] & ~s_reg.tck_sync[2];
      // Internal serial clock divider
      if (s_reg.cs_low) begin
         if (s_reg.div == SCK_HALF - 4'h1) begin
            s_next.div = 4'h0;
            s_next.sck = ~s_reg.sck;
            sck_fall = s_reg.sck;
         end else begin
            s_next.div = s_reg.div + 4'h1;
         end
      end else begin
         // Clock held low while deselected
         s_next.div = 4'h0;
         s_next.sck = 1'b0;
      end
      // Byte assembly shared by all data paths narrower than eight lanes
      // Flash data taken at the next falling edge: the pin
      // synchronisers delay it past the rising edge of its bit
      if (s_reg.st == ST_DATA && sck_fall) begin
         in_word = (lanes == 6'h04) ? 40'(s_reg.io_s2) :
                   (lanes == 6'h02) ? 40'(s_reg.io_s2[1:0]) :
                   40'(s_reg.so_s2);
      end else if (s_reg.st == ST_PASV && p_rise) begin
         in_word = {8'h00, s_reg.pdat_s2};
      end else if (s_reg.st == ST_JTAG && t_rise) begin
         in_word = 40'(s_reg.tdi_sync[1]);
      end
      // Unused upper lanes masked so idle pins cannot leak in
      in_word = in_word & ~(40'hFF_FFFF_FFFF << lanes);
      if ((s_reg.st == ST_DATA && sck_fall) || (s_reg.st == ST_PASV && p_rise)
          || (s_reg.st == ST_JTAG && t_rise)) begin
         // Narrow lanes pack msb first into a byte
         if (s_reg.st == ST_JTAG || lanes < 6'h08) begin
            s_next.byte_acc = 8'(({32'h0, s_reg.byte_acc} << lanes) | in_word);
            s_next.bit_cnt = s_reg.bit_cnt
               + ((s_reg.st == ST_JTAG) ? 6'h01 : lanes);
            if (s_next.bit_cnt >= 6'h08) begin
               s_next.bit_cnt = 6'h00;
               s_next.wr_en = 1'b1;
               s_next.wr_data = s_next.byte_acc;
               s_next.wr_addr = s_reg.bytes;
               s_next.bytes = s_reg.bytes + 32'h1;
            end
         end else begin
            // Wide passive words: low byte written each edge
            s_next.wr_en = 1'b1;
            s_next.wr_data = in_word[7:0];
            s_next.wr_addr = s_reg.bytes;
            s_next.bytes = s_reg.bytes + 32'h1;
         end
      end
      // Load sequencer
      case (s_reg.st)
         ST_IDLE: begin
            // Load starts on release of reset
            if (s_reg.rst_sync[1] & ~s_reg.rst_sync[2]) begin
               s_next.bytes = 32'h0;
               s_next.bit_cnt = 6'h00;
               // Mode pins sampled only here, at the start
               case (mode_sel)
                  MODE_PASSIVE: s_next.st = ST_PASV;
                  MODE_JTAG: s_next.st = ST_JTAG;
                  default: begin
                     s_next.st = ST_WAKE;
                     s_next.cs_low = 1'b1;
                     s_next.shreg = {CMD_WAKE, 32'h0000_0000};
                     s_next.cnt = 16'h0008;
                  end
               endcase
            end
         end
         ST_WAKE, ST_HDR: begin
            // Loader shifts its own command bytes out
            if (sck_fall) begin
               s_next.shreg = {s_reg.shreg[38:0], 1'b0};
               s_next.cnt = s_reg.cnt - 16'h1;
               // Last bit of the frame just went out
               if (s_reg.cnt == 16'h1) begin
                  if (s_reg.st == ST_WAKE) begin
                     s_next.cs_low = 1'b0;
                     s_next.st = ST_WAIT;
                     s_next.cnt = 16'(WAKE_WAIT_CYC);
                  end else begin
                     s_next.st = ST_DATA;
                  end
               end
            end
         end
         ST_WAIT: begin
            // Flash wake-up time counted in clock cycles
            if (s_reg.cnt == 16'h0) begin
               s_next.st = ST_HDR;
               s_next.cs_low = 1'b1;
               s_next.shreg = {CMD_FAST_READ, START_ADDR, 8'h00};
               s_next.cnt = 16'(HDR_BITS);
            end else begin
               s_next.cnt = s_reg.cnt - 16'h1;
            end
         end
         ST_DATA, ST_PASV, ST_JTAG: begin
            // Burst ends once the whole bitstream is stored
            if (s_next.bytes == 32'(BITSTREAM_BYTES)) begin
               s_next.cs_low = 1'b0;
               s_next.st = ST_DONE;
            end
         end
         ST_DONE: begin
            // Fabric released only after a complete load
            s_next.done = 1'b1;
         end
         default: s_next.st = ST_IDLE;
      endcase
      s_next.mosi = s_next.shreg[39];
      // Renewed reset aborts and waits for next release
      if (~s_reg.rst_sync[1]) begin
         s_next.st = ST_IDLE;
         s_next.cs_low = 1'b0;
         s_next.done = 1'b0;
      end
      // Serial clock parks low with the select, no stray edge at frame end
      if (!s_next.cs_low) begin
         s_next.sck = 1'b0;
         s_next.div = 4'h0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs taken straight from the state register
   assign flash_sck = s_reg.sck;
   assign flash_cs_b = ~s_reg.cs_low;
   assign flash_mosi = s_reg.mosi;
   assign cfg_wr_data = s_reg.wr_data;
   assign cfg_wr_en = s_reg.wr_en;
   assign cfg_wr_addr = s_reg.wr_addr;
   assign config_done = s_reg.done;
   assign fabric_enable = s_reg.done; // Fabric held until loaded
endmodule
`default_nettype wire

// ===== testbench/fcl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fcl_monitor
   import fcl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic config_reset_low,
   input wire logic [1:0] mode_sel,
   input wire logic flash_sck,
   input wire logic flash_cs_b,
   input wire logic flash_mosi,
   input wire logic cfg_wr_en,
   input wire logic config_done,
   input wire logic fabric_enable
);
   logic cs_reg;
   logic seen_reg;
   logic [15:0] hi_reg;
   logic [15:0] n_wr_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Deselect length, end of the wake frame, bytes stored this load
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_reg <= 1'b1;
         seen_reg <= 1'b0;
         hi_reg <= '0;
         n_wr_reg <= '0;
      end else begin
         cs_reg <= flash_cs_b;
         seen_reg <= config_reset_low & (seen_reg | (flash_cs_b & !cs_reg));
         hi_reg <= flash_cs_b ? hi_reg + 16'h0001 : '0;
         n_wr_reg <= config_reset_low ? n_wr_reg + 16'(cfg_wr_en) : '0;
      end
   end
   // Flash clock idle low, two cycles per half period
   sck_idle_a: assert property (flash_cs_b |-> !flash_sck)
      else $error("sck while idle");
   sck_rate_a: assert property ($rose(flash_sck) && config_reset_low
      |=> flash_sck ##1 !flash_sck)
      else $error("sck rate");
   // Start on release, stop on hold
   load_start_a: assert property ((!config_reset_low)[*4] ##1
      (config_reset_low && mode_sel == MODE_ACTIVE) |-> ##[1:6] !flash_cs_b)
      else $error("no start");
   load_abort_a: assert property ((!config_reset_low)[*6]
      |-> flash_cs_b && !config_done)
      else $error("no abort");
   wake_wait_a: assert property ($fell(flash_cs_b) && seen_reg
      |-> hi_reg >= 16'(WAKE_WAIT_CYC))
      else $error("wake gap short");
   mosi_hold_a: assert property (!flash_cs_b && !$past(flash_cs_b)
      && !$fell(flash_sck) |-> $stable(flash_mosi))
      else $error("mosi moved");
   fabric_off_a: assert property (!config_done |-> !fabric_enable)
      else $error("fabric early");
   done_len_a: assert property ($rose(config_done)
      |-> n_wr_reg == 16'(BITSTREAM_BYTES))
      else $error("done before full length");
   done_hold_a: assert property (config_done && config_reset_low |=> config_done)
      else $error("done lost");
   cover property ($rose(config_done));
   cover property ($fell(flash_cs_b) && seen_reg);
   cover property (cfg_wr_en && mode_sel == MODE_JTAG);
endmodule
`default_nettype wire

// ===== testbench/fcl_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fcl_flash_model (
   input wire logic flash_sck,
   input wire logic flash_cs_b,
   input wire logic flash_mosi,
   output logic flash_miso,
   output logic [7:0] wake_cmd,
   output logic [39:0] hdr,
   output logic [31:0] gap_ns
);
   logic [39:0] sh = '0;
   logic [7:0] v = '0;
   logic q = 1'b0;
   int bc = 0;
   time t_up = 0;
   // Deselected output shows the inverse of the last bit
   assign flash_miso = flash_cs_b ? !q : q;
   // Frame bounds: bit count, wake byte, idle gap
   always @(negedge flash_cs_b) begin
      bc = 0;
      gap_ns = 32'($time - t_up);
   end
   always @(posedge flash_cs_b) begin
      t_up = $time;
      if (bc == 8) wake_cmd = sh[7:0];
   end
   // Shift in on rise, data out msb first on fall
   always @(posedge flash_sck) begin
      sh = {sh[38:0], flash_mosi};
      bc++;
      if (bc == 40) hdr = sh;
   end
   always @(negedge flash_sck) if (bc >= 40) begin
      v = 8'((bc - 40) / 8) ^ 8'hA5;
      q = v[7 - (bc - 40) % 8];
   end
endmodule
`default_nettype wire

// ===== testbench/test_fpga_config_loader.sv
`timescale 1ns/1ns
`default_nettype none
module test_fpga_config_loader;
   import fcl_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic config_reset_low = 1'b0;
   logic [1:0] mode_sel = 2'h0;
   logic [2:0] width_sel = 3'h0;
   logic pasv_clk = 1'b0;
   logic [31:0] pasv_data = '0;
   logic tck = 1'b0;
   logic tdi = 1'b0;
   logic flash_sck, flash_cs_b, flash_mosi, flash_miso, cfg_wr_en, config_done, fabric_enable;
   logic [7:0] cfg_wr_data, wake_cmd;
   logic [31:0] cfg_wr_addr, gap_ns;
   logic [39:0] hdr;
   int wr_cnt = 0;
   int err_total = 0;
   int n_tests = 0;
   always #5 clk = !clk;
   fcl_loader u_dut (.clk, .rst_b, .config_reset_low, .mode_sel, .width_sel, .flash_miso,
      .flash_io_in({4{flash_miso}}), .pasv_clk, .pasv_data, .tck, .tdi, .flash_sck,
      .flash_cs_b, .flash_mosi, .cfg_wr_data, .cfg_wr_en, .cfg_wr_addr, .config_done,
      .fabric_enable);
   fcl_flash_model u_flash (.flash_sck, .flash_cs_b, .flash_mosi, .flash_miso, .wake_cmd,
      .hdr, .gap_ns);
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Pin held low, mode chosen, release starts a load
   task automatic load(input logic [1:0] m, input logic [2:0] w);
      config_reset_low = 1'b0;
      mode_sel = m;
      width_sel = w;
      step(8);
      wr_cnt = 0;
      config_reset_low = 1'b1;
   endtask
   // Each write carries the next address and its pattern byte
   always @(negedge clk) if (cfg_wr_en === 1'b1) begin
      chk(40'(cfg_wr_addr), 40'(wr_cnt));
      chk(40'(cfg_wr_data), 40'(8'(wr_cnt) ^ 8'hA5));
      wr_cnt++;
   end
   // Link units at 160 ns, msb first: k lanes per edge, a byte on wide buses
   task automatic link(input logic j, input int k, input int n);
      logic [7:0] v;
      logic [31:0] m;
      int kk;
      kk = (k > 8) ? 8 : k;
      m = (32'h0000_0001 << kk) - 32'h0000_0001;
      for (int p = 0; p < n * 8; p += kk) begin
         v = 8'(p / 8) ^ 8'hA5;
         tdi = v[7 - p % 8];
         pasv_data = (32'h5A5A_5A5A & ~m) | (32'(v >> (8 - kk - p % 8)) & m);
         #80;
         tck = j;
         pasv_clk = !j;
         #80;
         tck = 1'b0;
         pasv_clk = 1'b0;
      end
      step(10);
      chk(40'(wr_cnt), 40'(n));
   endtask
   task automatic final_report();
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Aborted load, full load, passive widths, then JTAG
   initial begin
      step(3);
      rst_b = 1'b1;
      load(MODE_ACTIVE, WID_X1);
      step(3500);
      load(MODE_ACTIVE, WID_X1);
      for (int i = 0; i < 40000 && config_done !== 1'b1; i++) step(1);
      chk(40'(wr_cnt), 40'(BITSTREAM_BYTES));
      chk(40'({config_done, fabric_enable, flash_cs_b}), 40'(7));
      chk(40'(wake_cmd), 40'(CMD_WAKE));
      chk(hdr, {CMD_FAST_READ, START_ADDR, 8'h00});
      chk(40'(gap_ns >= 32'(WAKE_WAIT_US * 1000)), 40'(1));
      for (int w = WID_X1; w <= WID_X32; w++) begin
         load(MODE_PASSIVE, 3'(w));
         link(1'b0, 1 << w, 8);
      end
      load(MODE_JTAG, WID_X1);
      link(1'b1, 1, 2);
      final_report();
   end
   // Watchdog
   initial begin
      #1000000;
      err_total++;
      final_report();
   end
endmodule
bind fcl_loader fcl_monitor u_mon (.clk, .rst_b, .config_reset_low, .mode_sel, .flash_sck,
   .flash_cs_b, .flash_mosi, .cfg_wr_en, .config_done, .fabric_enable);
`default_nettype wire
